//--- src/acl_rule_match_engine.sv
// Access-control rule matcher with APB rule table
//
// Added by the designer: the address map and the APB register port.
`include "acl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module acl_rule_match_engine
  import acl_pkg::*;
#(
  parameter int NRULE = `ACL_NRULE,
  parameter int MS_US = `ACL_MS_US
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        pkt_valid,
  input  wire logic [47:0] pkt_dmac,
  input  wire logic [47:0] pkt_smac,
  input  wire logic [15:0] pkt_etype,
  input  wire logic        pkt_is_ip,
  input  wire logic [31:0] pkt_dip,
  input  wire logic [31:0] pkt_sip,
  input  wire logic [7:0]  pkt_proto,
  input  wire logic        pkt_is_tcp,
  input  wire logic        pkt_is_udp,
  input  wire logic [15:0] pkt_dport,
  input  wire logic [15:0] pkt_sport,
  input  wire logic [31:0] pkt_seq,
  input  wire logic [7:0]  pkt_flags,
  output var  logic        act_valid,
  output var  logic        act_hit,
  output var  logic [3:0]  act_index,
  output var  logic [31:0] act_word,
  output var  logic        count_irq
);

  localparam int NW = NRULE * `ACL_WPE;

  logic [31:0]      tbl_ff [NW];
  logic [10:0]      cnt_ff [NRULE];
  logic [NRULE-1:0] stat_ff;
  logic [NRULE-1:0] mask_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic             act_valid_ff;
  logic             act_hit_ff;
  logic [3:0]       act_index_ff;
  logic [31:0]      act_word_ff;
  logic             irq_ff;
  logic [5:0]       us_div_ff;
  logic [9:0]       ms_div_ff;
  logic             us_tick;
  logic             ms_tick;
  logic [NRULE-1:0] rule_true;
  logic [NRULE-1:0] cnt_hit;
  logic [NRULE-1:0] cnt_mode;
  logic [NRULE-1:0] ptr_true;
  logic [NRULE-1:0] irq_set;
  logic             sel_hit;
  logic [3:0]       sel_idx;
  logic             wr_en;
  logic             tbl_acc;
  logic [6:0]       widx;

  function automatic logic [31:0] word_of(input int r,
                                          input logic [2:0] w);
    word_of = tbl_ff[r * `ACL_WPE + int'(w)];
  endfunction

  function automatic logic port_ok(input logic [1:0]  pc,
                                   input logic [15:0] p,
                                   input logic [15:0] mx,
                                   input logic [15:0] mn);
    case (acl_pc_t'(pc))
      ACL_PC_OFF: port_ok = 1'b1;
      ACL_PC_ONE: port_ok = (p == mx) || (p == mn);
      ACL_PC_IN:  port_ok = (p >= mn) && (p <= mx);
      ACL_PC_OUT: port_ok = (p < mn) || (p > mx);
      default:    port_ok = 1'b0;
    endcase
  endfunction

  // APB decode: zero wait states, answer in the access cycle
  assign wr_en   = psel && penable && pready_ff && pwrite;
  assign tbl_acc = paddr <= `ACL_A_TBLTOP;
  assign widx    = paddr[8:2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
      if (psel && !penable) begin
        if (tbl_acc) begin
          prdata_ff <= tbl_ff[widx];
        end else begin
          case (paddr)
            `ACL_A_STAT: prdata_ff <= 32'(stat_ff);
            `ACL_A_MASK: prdata_ff <= 32'(mask_ff);
            `ACL_A_RES:  prdata_ff <= {act_hit_ff, 27'h0, act_index_ff};
            default:     pslverr_ff <= 1'b1;
          endcase
        end
      end
    end
  end

  // Rule table storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NW; i++) begin
        tbl_ff[i] <= 32'h0;
      end
    end else if (wr_en && tbl_acc) begin
      tbl_ff[widx] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= '0;
    end else if (wr_en && paddr == `ACL_A_MASK) begin
      mask_ff <= pwdata[NRULE-1:0];
    end
  end

  // Status is write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
    end else begin
      if (wr_en && paddr == `ACL_A_STAT) begin
        stat_ff <= (stat_ff & ~pwdata[NRULE-1:0]) | irq_set;
      end else begin
        stat_ff <= stat_ff | irq_set;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // Time base: microsecond and millisecond enable pulses
  assign us_tick = us_div_ff == 6'(`ACL_US_CYC - 1);
  assign ms_tick = us_tick && ms_div_ff == 10'(MS_US - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_div_ff <= 6'h0;
      ms_div_ff <= 10'h0;
    end else begin
      us_div_ff <= us_tick ? 6'h0 : us_div_ff + 6'h1;
      if (ms_tick) begin
        ms_div_ff <= 10'h0;
      end else if (us_tick) begin
        ms_div_ff <= ms_div_ff + 10'h1;
      end
    end
  end

  // Evaluate every matching rule against the header
  always_comb begin
    logic [31:0] c;
    logic [31:0] a;
    logic [31:0] l2;
    logic [31:0] m;
    logic [31:0] pw;
    logic [31:0] fw;
    logic [47:0] mac;
    logic [47:0] pmac;
    logic [31:0] pip;
    logic [15:0] pp;
    logic        raw;
    logic        ok;
    c = 32'h0; a = 32'h0; l2 = 32'h0; m = 32'h0;
    pw = 32'h0; fw = 32'h0; mac = 48'h0; pmac = 48'h0;
    pip = 32'h0; pp = 16'h0; raw = 1'b0; ok = 1'b0;
    rule_true = '0;
    cnt_hit   = '0;
    cnt_mode  = '0;
    for (int r = 0; r < NRULE; r++) begin
      c    = word_of(r, `ACL_W_CTRL);
      a    = word_of(r, `ACL_W_ADR);
      l2   = word_of(r, `ACL_W_L2);
      m    = word_of(r, `ACL_W_MSK);
      pw   = word_of(r, `ACL_W_PORT);
      fw   = word_of(r, `ACL_W_FLG);
      mac  = {l2[`ACL_F_MACHI], a};
      pmac = c[`ACL_F_SRC] ? pkt_smac : pkt_dmac;
      pip  = c[`ACL_F_SRC] ? pkt_sip : pkt_dip;
      pp   = c[`ACL_F_SRC] ? pkt_sport : pkt_dport;
      raw  = 1'b0;
      ok   = 1'b1;
      case (acl_md_t'(c[`ACL_F_MD]))
        ACL_MD_OFF: ok = 1'b0;
        ACL_MD_L2: begin
          case (c[`ACL_F_SEL])
            2'h1:    raw = pkt_etype == l2[`ACL_F_ETYPE];
            2'h2:    raw = pmac == mac;
            default: raw = pmac == mac && pkt_etype == l2[`ACL_F_ETYPE];
          endcase
        end
        ACL_MD_L3: begin
          ok = pkt_is_ip;
          case (c[`ACL_F_SEL])
            2'h1:    raw = ((pip ^ a) & ~m) == 32'h0;
            2'h2:    raw = pkt_sip == a && pkt_dip == m;
            default: ok = 1'b0;
          endcase
        end
        ACL_MD_L4: begin
          ok = pkt_is_ip;
          case (c[`ACL_F_SEL])
            2'h0: raw = pkt_proto == c[`ACL_F_PRO];
            2'h1: begin
              ok  = ok && pkt_is_tcp;
              raw = port_ok(c[`ACL_F_PC], pp, pw[`ACL_F_PMAX], pw[`ACL_F_PMIN]);
            end
            2'h2: begin
              ok  = ok && pkt_is_udp;
              raw = port_ok(c[`ACL_F_PC], pp, pw[`ACL_F_PMAX], pw[`ACL_F_PMIN]);
            end
            default: begin
              ok  = ok && pkt_is_tcp;
              raw = pkt_seq == pw;
            end
          endcase
          // Flags only mean something on TCP frames
          if (c[`ACL_F_FME]) begin
            ok  = ok && pkt_is_tcp;
            raw = raw && ((pkt_flags ^ fw[`ACL_F_FLAG])
                          & ~fw[`ACL_F_FMSK]) == 8'h0;
          end
        end
        default: ok = 1'b0;
      endcase
      // Count rules hold no forwarding action, so they stay out of resolution
      cnt_mode[r] = c[`ACL_F_MD] == ACL_MD_L2 && c[`ACL_F_SEL] == 2'h0;
      cnt_hit[r]  = cnt_mode[r] && pkt_valid && (raw == c[`ACL_F_EQ]);
      rule_true[r] = ok && !cnt_mode[r] && (raw == c[`ACL_F_EQ]);
    end
  end

  // Processing entries: AND inside a set, OR per pointer
  always_comb begin
    logic [31:0] p;
    logic [15:0] rs;
    p = 32'h0;
    rs = 16'h0;
    ptr_true = '0;
    for (int e = 0; e < NRULE; e++) begin
      p  = word_of(e, `ACL_W_PROC);
      rs = p[`ACL_F_RSM];
      if (rs != 16'h0 && (rs[NRULE-1:0] & ~rule_true) == '0) begin
        ptr_true[p[`ACL_F_PTR]] = 1'b1;
      end
    end
  end

  always_comb begin
    sel_hit = 1'b0;
    sel_idx = 4'h0;
    for (int k = NRULE - 1; k >= 0; k--) begin
      if (ptr_true[k]) begin
        sel_hit = 1'b1;
        sel_idx = 4'(k);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_valid_ff <= 1'b0;
      act_hit_ff   <= 1'b0;
      act_index_ff <= 4'h0;
      act_word_ff  <= 32'h0;
    end else begin
      act_valid_ff <= pkt_valid;
      if (pkt_valid) begin
        act_hit_ff   <= sel_hit;
        act_index_ff <= sel_idx;
        act_word_ff  <= sel_hit ? word_of(int'(sel_idx), `ACL_W_ACT) : 32'h0;
      end
    end
  end

  // Count-mode counters, one per matching rule
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < NRULE; r++) begin
        cnt_ff[r] <= 11'h0;
      end
      irq_set <= '0;
    end else begin
      irq_set <= '0;
      for (int r = 0; r < NRULE; r++) begin
        logic [31:0] ac;
        logic        tick;
        ac   = word_of(r, `ACL_W_ACT);
        tick = ac[`ACL_F_TU] ? ms_tick : us_tick;
        if (!cnt_mode[r]) begin
          cnt_ff[r] <= 11'h0;
        end else if (ac[`ACL_F_CA]) begin
          if (cnt_hit[r]) begin
            if (cnt_ff[r] + 11'h1 >= ac[`ACL_F_CNT]) begin
              irq_set[r] <= 1'b1;
              cnt_ff[r]  <= 11'h0;
            end else begin
              cnt_ff[r] <= cnt_ff[r] + 11'h1;
            end
          end
        end else if (cnt_hit[r] || cnt_ff[r] == 11'h0) begin
          cnt_ff[r] <= ac[`ACL_F_CNT];
        end else if (tick) begin
          if (cnt_ff[r] == 11'h1) begin
            irq_set[r] <= 1'b1;
            cnt_ff[r]  <= ac[`ACL_F_CNT];
          end else begin
            cnt_ff[r] <= cnt_ff[r] - 11'h1;
          end
        end
      end
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign act_valid = act_valid_ff;
  assign act_hit   = act_hit_ff;
  assign act_index = act_index_ff;
  assign act_word  = act_word_ff;
  assign count_irq = irq_ff;

endmodule // acl_rule_match_engine
`default_nettype wire

//--- src/acl_params.svh
// Constants for the access-control rule matcher
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH
`define ACL_AW 10
`define ACL_NRULE 16
`define ACL_WPE 8
// Word index inside one table entry
`define ACL_W_CTRL 3'd0
`define ACL_W_ADR 3'd1
`define ACL_W_L2 3'd2
`define ACL_W_MSK 3'd3
`define ACL_W_PORT 3'd4
`define ACL_W_FLG 3'd5
`define ACL_W_ACT 3'd6
`define ACL_W_PROC 3'd7
// Control word fields
`define ACL_F_MD 1:0
`define ACL_F_SEL 3:2
`define ACL_F_SRC 4
`define ACL_F_EQ 5
`define ACL_F_PC 7:6
`define ACL_F_FME 8
`define ACL_F_PRO 23:16
// Other word fields
`define ACL_F_MACHI 15:0
`define ACL_F_ETYPE 31:16
`define ACL_F_PMIN 15:0
`define ACL_F_PMAX 31:16
`define ACL_F_FLAG 7:0
`define ACL_F_FMSK 15:8
`define ACL_F_CNT 10:0
`define ACL_F_TU 11
`define ACL_F_CA 12
`define ACL_F_RSM 15:0
`define ACL_F_PTR 19:16
// Global registers and the last rule table address
`define ACL_A_STAT 10'h200
`define ACL_A_MASK 10'h204
`define ACL_A_RES 10'h208
`define ACL_A_TBLTOP 10'h1ff
// Timing
`define ACL_CLK_NS 25
`define ACL_US_NS 1000
`define ACL_US_CYC (`ACL_US_NS / `ACL_CLK_NS)
`define ACL_MS_US 1000
`endif

//--- src/acl_pkg.sv
// Types for the access-control rule matcher
package acl_pkg;
  typedef enum logic [1:0] {
    ACL_MD_OFF = 2'h0,
    ACL_MD_L2  = 2'h1,
    ACL_MD_L3  = 2'h2,
    ACL_MD_L4  = 2'h3
  } acl_md_t;
  typedef enum logic [1:0] {
    ACL_PC_OFF = 2'h0,
    ACL_PC_ONE = 2'h1,
    ACL_PC_IN  = 2'h2,
    ACL_PC_OUT = 2'h3
  } acl_pc_t;
endpackage

//--- bench/acl_rule_match_engine_asserts.sv
// Port checker for the access-control rule matcher
`timescale 1ns/1ps
`default_nettype none
module acl_rule_match_engine_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pkt_valid,
  input wire logic        act_valid,
  input wire logic        act_hit,
  input wire logic [3:0]  act_index,
  input wire logic [31:0] act_word
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ACT_LAT: assert property (pkt_valid |=> act_valid)
    else $error("no result one cycle after a header");
  AST_ACT_NONE: assert property (!pkt_valid |=> !act_valid)
    else $error("result without a header");
  AST_ACT_HOLD: assert property (!pkt_valid |=>
    $stable(act_hit) && $stable(act_index) && $stable(act_word))
    else $error("result changed between headers");
  AST_NOHIT_ZERO: assert property (act_valid && !act_hit |-> act_word == 32'h0)
    else $error("action word set without a hit");
  AST_APB_RDY: assert property (psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("ready stood two cycles");
  AST_ERR_MAP: assert property (psel && !penable && paddr > 10'h20b |=> pslverr)
    else $error("unmapped address not refused");
  AST_ERR_READ: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
endmodule // acl_rule_match_engine_chk
bind acl_rule_match_engine acl_rule_match_engine_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pkt_valid(pkt_valid), .act_valid(act_valid), .act_hit(act_hit),
  .act_index(act_index), .act_word(act_word));
`default_nettype wire

//--- bench/acl_pkt_src.sv
// Ingress parser model: one-cycle header pulses
`timescale 1ns/1ps
`default_nettype none
module acl_pkt_src (
  input wire logic         pclk,
  output var logic         pkt_valid,
  output var logic [47:0]  pkt_dmac,
  output var logic [47:0]  pkt_smac,
  output var logic [15:0]  pkt_etype,
  output var logic         pkt_is_ip,
  output var logic [31:0]  pkt_dip,
  output var logic [31:0]  pkt_sip,
  output var logic [7:0]   pkt_proto,
  output var logic         pkt_is_tcp,
  output var logic         pkt_is_udp,
  output var logic [15:0]  pkt_dport,
  output var logic [15:0]  pkt_sport,
  output var logic [31:0]  pkt_seq,
  output var logic [7:0]   pkt_flags
);
  initial begin
    {pkt_valid, pkt_dmac, pkt_smac, pkt_etype, pkt_is_ip, pkt_dip, pkt_sip} = '0;
    {pkt_proto, pkt_is_tcp, pkt_is_udp, pkt_dport, pkt_sport, pkt_seq, pkt_flags} = '0;
  end
  task send(input logic [47:0] m, input logic [15:0] t, input logic [31:0] s,
            input logic [7:0] p, input logic [15:0] d);
    @(posedge pclk);
    pkt_valid <= 1'b1;
    {pkt_dmac, pkt_smac, pkt_etype, pkt_is_ip} <= {m, ~m, t, 1'b1};
    {pkt_sip, pkt_dip, pkt_seq, pkt_proto, pkt_flags} <= {s, ~s, ~s, p, p};
    {pkt_is_tcp, pkt_is_udp} <= {p == 8'h06, p == 8'h11};
    {pkt_dport, pkt_sport} <= {d, ~d};
    @(posedge pclk);
    // MAC, type, IP address and dest port fields are stale outside the pulse, so show their inverse
    pkt_valid <= 1'b0;
    {pkt_dmac, pkt_smac, pkt_etype, pkt_sip, pkt_dip, pkt_dport}
      <= ~{pkt_dmac, pkt_smac, pkt_etype, pkt_sip, pkt_dip, pkt_dport};
  endtask
endmodule // acl_pkt_src
`default_nettype wire

//--- bench/testbench.sv
// Directed bench for the access-control rule matcher
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, act_word, rd, pkt_dip, pkt_sip, pkt_seq;
  logic        act_valid, act_hit, count_irq, pkt_valid, pkt_is_ip, pkt_is_tcp, pkt_is_udp;
  logic [3:0]  act_index;
  logic [47:0] pkt_dmac, pkt_smac;
  logic [15:0] pkt_etype, pkt_dport, pkt_sport;
  logic [7:0]  pkt_proto, pkt_flags;
  logic [41:0] cfg [17];
  int          n_fail = 0, n_compared = 0, cyc = 0;
  acl_rule_match_engine #(.MS_US(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_dmac(pkt_dmac),
    .pkt_smac(pkt_smac), .pkt_etype(pkt_etype), .pkt_is_ip(pkt_is_ip), .pkt_dip(pkt_dip),
    .pkt_sip(pkt_sip), .pkt_proto(pkt_proto), .pkt_is_tcp(pkt_is_tcp),
    .pkt_is_udp(pkt_is_udp), .pkt_dport(pkt_dport), .pkt_sport(pkt_sport),
    .pkt_seq(pkt_seq), .pkt_flags(pkt_flags), .act_valid(act_valid), .act_hit(act_hit),
    .act_index(act_index), .act_word(act_word), .count_irq(count_irq));
  acl_pkt_src i_src (.pclk(pclk), .pkt_valid(pkt_valid), .pkt_dmac(pkt_dmac),
    .pkt_smac(pkt_smac), .pkt_etype(pkt_etype), .pkt_is_ip(pkt_is_ip), .pkt_dip(pkt_dip),
    .pkt_sip(pkt_sip), .pkt_proto(pkt_proto), .pkt_is_tcp(pkt_is_tcp),
    .pkt_is_udp(pkt_is_udp), .pkt_dport(pkt_dport), .pkt_sport(pkt_sport),
    .pkt_seq(pkt_seq), .pkt_flags(pkt_flags));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  task ap(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task pk(input logic [47:0] m, input logic [15:0] t, input logic [31:0] s,
          input logic [7:0] p, input logic [15:0] d, input logic h, input logic [3:0] x);
    i_src.send(m, t, s, p, d);
    #1;
    `CHK("valid", 1'b1, act_valid)
    `CHK("hit", h, act_hit)
    `CHK("word", h ? {28'hac00000, x} : 32'h0, act_word)
    if (h) `CHK("index", x, act_index)
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, err, rd} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Rule 0 dest MAC, 1 masked source IPv4, 2 UDP range, 7 counter
    cfg = '{{10'h000, 32'h29}, {10'h004, 32'h1}, {10'h008, 32'h200},
            {10'h020, 32'h36}, {10'h024, 32'h0a000000}, {10'h02c, 32'hff},
            {10'h040, 32'hab}, {10'h050, 32'h01000050},
            {10'h0e0, 32'h21}, {10'h0e4, 32'h7}, {10'h0e8, 32'h88b50200},
            {10'h0f8, 32'h1002}, {10'h01c, 32'h60001}, {10'h03c, 32'h50002},
            {10'h05c, 32'h60004}, {10'h07c, 32'h40003}, {10'h204, 32'h80}};
    foreach (cfg[i]) ap(1'b1, cfg[i][41:32], cfg[i][31:0]);
    for (int e = 4; e < 7; e++) ap(1'b1, 10'(32 * e + 24), 32'hac000000 | 32'(e));
    ap(1'b0, 10'h020, 32'h0); `CHK("table", 32'h36, rd)
    ap(1'b0, 10'h20c, 32'h0); `CHK("slverr", 1'b1, err)
    pk(48'h020000000001, 0, 32'h0b000001, 8'h06, 0, 1'b1, 4'h6);
    pk(48'h020000000001, 0, 32'h0a000033, 8'h06, 0, 1'b1, 4'h4);
    pk(48'h0, 0, 32'h0a0000ff, 8'h06, 0, 1'b1, 4'h5);
    pk(48'h0, 0, 32'h0b000000, 8'h11, 16'h100, 1'b1, 4'h6);
    pk(48'h0, 0, 32'h0b000000, 8'h11, 16'h101, 1'b0, 4'h0);
    pk(48'h0, 0, 32'h0b000000, 8'h06, 16'h80, 1'b0, 4'h0);
    ap(1'b1, 10'h000, 32'h09);
    pk(48'h0, 0, 32'h0b000000, 8'h06, 0, 1'b1, 4'h6);
    ap(1'b1, 10'h000, 32'h28);
    pk(48'h0, 0, 32'h0b000000, 8'h06, 0, 1'b0, 4'h0);
    // Two counted packets reach a count of two
    pk(48'h020000000007, 16'h88b5, 32'h0b000000, 8'h06, 0, 1'b0, 4'h0);
    repeat (3) @(posedge pclk);
    `CHK("irq early", 1'b0, count_irq)
    pk(48'h020000000007, 16'h88b5, 32'h0b000000, 8'h06, 0, 1'b0, 4'h0);
    repeat (3) @(posedge pclk);
    `CHK("irq", 1'b1, count_irq)
    ap(1'b0, 10'h200, 32'h0); `CHK("status", 32'h80, rd)
    ap(1'b1, 10'h200, 32'h80);
    ap(1'b0, 10'h200, 32'h0); `CHK("cleared", 32'h0, rd)
    `CHK("irq clear", 1'b0, count_irq)
    // Watchdog of three microseconds with no packet: expires after three ticks
    ap(1'b1, 10'h0f8, 32'h3);
    repeat (40) @(posedge pclk);
    `CHK("wdog early", 1'b0, count_irq)
    repeat (160) @(posedge pclk);
    `CHK("wdog irq", 1'b1, count_irq)
    summarize();
  end
endmodule // testbench
`default_nettype wire
